// >>> tmc_pkg.sv
// package of the transceiver mode controller: states, timings, host register map
// assumes a single 50 MHz clock shared by both ends of the link
package tmc_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   // delays in their own unit (ns); values are plain defaults
   localparam int unsigned SLEEP_DELAY_NS   = 50000;
   localparam int unsigned STARTUP_DELAY_NS = 40000;
   localparam int unsigned SILENCE_NS       = 1000000;
   localparam int unsigned UV_SLEEP_NS      = 200000000;
   // least times round up to whole cycles
   localparam int unsigned SLEEP_CYC   = (SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STARTUP_CYC = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SILENCE_CYC = (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UV_SLP_CYC  = (UV_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W       = 32;

   // ***************************************************************
   // operating modes, one-hot
   // ***************************************************************
   typedef enum logic [4:0] {
      TMC_OFF      = 5'h01,
      TMC_STANDBY  = 5'h02,
      TMC_NORMAL   = 5'h04,
      TMC_SLEEP    = 5'h08,
      TMC_OVERTEMP = 5'h10
   } tmc_mode_t;

   // ***************************************************************
   // host register map (AHB-Lite, one word each)
   // ***************************************************************
   localparam logic [31:0] TMC_CTRL_ADDR   = 32'h0000_0000;
   localparam logic [31:0] TMC_STATUS_ADDR = 32'h0000_0004;
   localparam int unsigned TMC_ADDR_W      = 4;
   localparam int unsigned CTRL_NORMAL_BIT = 0;
   localparam int unsigned STAT_RX_BIT     = 0;
   localparam int unsigned STAT_WAKE_BIT   = 1;
   localparam logic        CTRL_RESET      = 1'b0;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;

endpackage : tmc_pkg

// >>> tmc_if.sv
// link between the host controller and the mode controller
// assumes both ends on the same clock; pins are plain logic levels
`timescale 1ns/10ps
interface tmc_if;
   logic sleep_request_low;   // host drives; low asks for standby/sleep
   logic rx_out;              // device drives; low flags pending wake or bus data
   modport dev  (input sleep_request_low, output rx_out);
   modport host (output sleep_request_low, input rx_out);
endinterface : tmc_if

// >>> tmc_device.sv
// operating-mode state machine of a bus transceiver with integrated regulator
// assumes comparator results and wake detections arrive as synchronous levels
//
// Function
// (R1) exactly five modes: normal standby sleep overtemp off
// (R2) standby to normal on sleep_request_low high, io ok
// (R3) normal to standby when sleep_request_low goes low
// (R4) normal to standby on io undervoltage
// (R5) normal to overtemp at once on trip
// (R6) any mode to off below power-off threshold
// (R7) entering normal clears all pending wakes
// (R8) standby: no data, inhibit active, watch wake
// (R9) standby bias ground after silence, mid when active
// (R10) standby/sleep: rx low once wake detected
// (R11) sleep to standby on wake or request
// (R12) sleep like standby, inhibit floats, no overtemp
// (R13) standby to sleep after sleep delay, none pending
// (R14) host clears pending wakes only via normal
// (R15) long io undervoltage forces sleep, clears wakes
// (R16) off: power-on detect, standby after startup delay
// (R17) off to standby drives rx low
// (R18) off: bus pins float, no load
// (R19) overtemp: all off, inhibit held, keep signalling
// (R20) overtemp to standby on release, off on battery
// (R21) standby regulator on wake or request, silence timeout; here a bus wake only, a local wake leaves it off
// (R22) rx stays low from off exit to normal
// (R23) digital comparator inputs, parameterised delay counters
// (R24) pending latches per cause, rx is their or
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module tmc_device
   import tmc_pkg::*;
#(
   parameter int unsigned SILENCE_CYCLES = tmc_pkg::SILENCE_CYC,
   parameter int unsigned UV_SLP_CYCLES  = tmc_pkg::UV_SLP_CYC
) (
   input  wire logic             CLK,
   input  wire logic             NRST,
   tmc_if.dev                    LINK,
   input  wire logic             POWER_ON_ABOVE,
   input  wire logic             POWER_OFF_BELOW,
   input  wire logic             IO_UNDERVOLTAGE,
   input  wire logic             OVERTEMP_TRIP,
   input  wire logic             OVERTEMP_RELEASE,
   input  wire logic             BUS_ACTIVITY,
   input  wire logic             BUS_WAKE_PATTERN,
   input  wire logic             LOCAL_WAKE_PIN,
   input  wire logic             RX_BUS_DATA,
   output tmc_pkg::tmc_mode_t    MODE,
   output logic                  REGULATOR_ON,
   output logic                  REGULATOR_SWITCH_O,
   output logic                  REGULATOR_SWITCH_OE,
   output logic                  TX_ENABLE,
   output logic                  RX_ENABLE,
   output logic                  BIAS_MID,
   output logic                  BIAS_GND,
   output logic                  BUS_FLOAT
);
   import tmc_pkg::*;

   // ***************************************************************
   // state and counters
   // ***************************************************************
   tmc_mode_t        mode_q, mode_d;                   // (R1)
   logic [CNT_W-1:0] sleep_cnt_q, startup_cnt_q, silence_cnt_q, uv_cnt_q, reg_cnt_q;
   logic             pend_pon_q, pend_bus_q, pend_loc_q;
   logic             wake_prev_q;
   logic             reg_q;
   logic             inh_q;
   logic             rx_q;

   wire in_off      = (mode_q == TMC_OFF);
   wire in_standby  = (mode_q == TMC_STANDBY);
   wire in_normal   = (mode_q == TMC_NORMAL);
   wire in_sleep    = (mode_q == TMC_SLEEP);
   wire in_ot       = (mode_q == TMC_OVERTEMP);
   wire sleep_req   = LINK.sleep_request_low;   // pin high selects normal, low standby/sleep
   wire io_ok       = ~IO_UNDERVOLTAGE;

   // wake detection only in standby and sleep; overtemp and off see none
   wire wake_window = in_standby | in_sleep;                              // (R19)
   wire local_edge  = wake_window & (LOCAL_WAKE_PIN ^ wake_prev_q);
   wire bus_wake    = wake_window & BUS_WAKE_PATTERN;                     // (R8)
   wire any_pending = pend_pon_q | pend_bus_q | pend_loc_q;              // (R24)

   // delay expiries; counters saturate so an expiry stays set until its counter clears
   wire sleep_done   = (sleep_cnt_q   >= CNT_W'(SLEEP_CYC - 1));         // (R23)
   wire startup_done = (startup_cnt_q >= CNT_W'(STARTUP_CYC - 1));       // (R23)
   wire bus_silent   = (silence_cnt_q >= CNT_W'(SILENCE_CYCLES - 1));    // (R23)
   wire reg_timeout  = (reg_cnt_q     >= CNT_W'(SILENCE_CYCLES - 1));    // (R21)
   wire uv_force     = IO_UNDERVOLTAGE & ~in_off & ~in_ot
                       & (uv_cnt_q == CNT_W'(UV_SLP_CYCLES - 1));         // (R15)
   wire enter_normal = (mode_d == TMC_NORMAL) & ~in_normal;
   wire pend_clear   = enter_normal | uv_force;                           // (R7) (R15)
   wire off_exit     = in_off & (mode_d == TMC_STANDBY);

   // ***************************************************************
   // next-mode selection; battery loss overrides everything
   // ***************************************************************
   always_comb begin
      mode_d = mode_q;
      if (POWER_OFF_BELOW) begin
         mode_d = TMC_OFF;                                                // (R6)
      end else begin
         unique case (mode_q)
            TMC_OFF: begin
               if (POWER_ON_ABOVE && startup_done) begin
                  mode_d = TMC_STANDBY;                                   // (R16)
               end
            end
            TMC_NORMAL: begin
               if (OVERTEMP_TRIP) begin
                  mode_d = TMC_OVERTEMP;                                  // (R5)
               end else if (!sleep_req) begin
                  mode_d = TMC_STANDBY;                                   // (R3)
               end else if (!io_ok) begin
                  mode_d = TMC_STANDBY;                                   // (R4)
               end
            end
            TMC_STANDBY: begin
               if (uv_force) begin
                  mode_d = TMC_SLEEP;                                     // (R15)
               end else if (sleep_req && io_ok) begin
                  mode_d = TMC_NORMAL;                                    // (R2)
               end else if (!sleep_req && sleep_done && !any_pending) begin
                  mode_d = TMC_SLEEP;                                     // (R13)
               end
            end
            TMC_SLEEP: begin
               // temperature is not watched here
               if (local_edge || bus_wake || (sleep_req && io_ok)) begin
                  mode_d = TMC_STANDBY;                                   // (R11) (R12)
               end
            end
            TMC_OVERTEMP: begin
               if (OVERTEMP_RELEASE) begin
                  mode_d = TMC_STANDBY;                                   // (R20)
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // mode register
   // ***************************************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) mode_q <= TMC_OFF;
      else       mode_q <= mode_d;
   end

   // ***************************************************************
   // delay counters, all on the free-running clock
   // ***************************************************************
   // sleep delay runs only while standby holds the low request
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sleep_cnt_q <= '0;
         startup_cnt_q <= '0;
      end else begin
         sleep_cnt_q <= (in_standby && !sleep_req) ? (sleep_done ? sleep_cnt_q : sleep_cnt_q + 1'b1)
                                                   : '0;         // (R13)
         startup_cnt_q <= (in_off && POWER_ON_ABOVE) ? (startup_done ? startup_cnt_q
                                                       : startup_cnt_q + 1'b1) : '0; // (R16)
      end
   end

   // bus silence and io undervoltage persistence
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         silence_cnt_q <= '0;
         uv_cnt_q <= '0;
      end else begin
         silence_cnt_q <= BUS_ACTIVITY ? '0 : (bus_silent ? silence_cnt_q : silence_cnt_q + 1'b1);
         uv_cnt_q <= (IO_UNDERVOLTAGE && !in_off) ? ((uv_cnt_q == CNT_W'(UV_SLP_CYCLES - 1))
                     ? uv_cnt_q : uv_cnt_q + 1'b1) : '0;                  // (R15)
      end
   end

   // ***************************************************************
   // regulator control in standby
   // ***************************************************************
   // a bus wake powers the regulator for one silence timeout; a request keeps it on
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         reg_q <= 1'b0;
         reg_cnt_q <= '0;
      end else if (!in_standby) begin
         reg_q <= 1'b0;
         reg_cnt_q <= '0;
      end else if (bus_wake || sleep_req) begin
         reg_q <= 1'b1;                                                   // (R21)
         reg_cnt_q <= '0;
      end else if (reg_q) begin
         reg_q <= ~reg_timeout;                                           // (R21)
         reg_cnt_q <= reg_timeout ? reg_cnt_q : reg_cnt_q + 1'b1;
      end
   end

   // ***************************************************************
   // pending wake latches; a new detection beats a clear in the same cycle
   // ***************************************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pend_pon_q <= 1'b0;
         pend_bus_q <= 1'b0;
         pend_loc_q <= 1'b0;
         wake_prev_q <= 1'b0;
      end else begin
         pend_pon_q <= off_exit | (pend_pon_q & ~pend_clear);             // (R17) (R22) (R24)
         pend_bus_q <= bus_wake | (pend_bus_q & ~pend_clear);             // (R10) (R24)
         pend_loc_q <= local_edge | (pend_loc_q & ~pend_clear);           // (R10) (R24)
         wake_prev_q <= LOCAL_WAKE_PIN;
      end
   end

   // ***************************************************************
   // inhibit: active in standby/normal, floats in sleep/off, held in overtemp
   // ***************************************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) inh_q <= 1'b0;
      else if (mode_d == TMC_STANDBY || mode_d == TMC_NORMAL) inh_q <= 1'b1; // (R8)
      else if (mode_d == TMC_SLEEP || mode_d == TMC_OFF) inh_q <= 1'b0;      // (R12)
      // overtemp keeps whatever inhibit was                              (R19)
   end

   // ***************************************************************
   // receive output: bus data in normal, high in off, else low while anything pends
   // ***************************************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) rx_q <= 1'b1;
      else if (mode_d == TMC_NORMAL) rx_q <= RX_BUS_DATA;
      else if (mode_d == TMC_OFF) rx_q <= 1'b1;
      else rx_q <= ~(any_pending | off_exit | bus_wake | local_edge);     // (R10) (R19) (R22)
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign LINK.rx_out         = rx_q;
   assign MODE                = mode_q;
   assign REGULATOR_ON        = in_normal | (in_standby & reg_q);         // (R19) (R21)
   assign REGULATOR_SWITCH_O  = 1'b1;
   assign REGULATOR_SWITCH_OE = inh_q;
   assign TX_ENABLE           = in_normal & io_ok;                        // (R8) (R19)
   assign RX_ENABLE           = in_normal & io_ok;
   assign BUS_FLOAT           = in_off | in_ot;                           // (R18) (R19)
   assign BIAS_GND            = wake_window & bus_silent;                 // (R9)
   assign BIAS_MID            = in_normal | (wake_window & ~bus_silent);  // (R9)

endmodule : tmc_device

// >>> tmc_host.sv
// host end: AHB-Lite registers that drive the sleep request and read the rx line
// assumes the rx line is synchronous to CLK; one slave, always OKAY
`timescale 1ns/10ps
module tmc_host
   import tmc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   tmc_if.host              LINK,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP
);
   import tmc_pkg::*;

   // ***************************************************************
   // address phase capture
   // ***************************************************************
   logic        wr_q;
   logic [31:0] addr_q;
   logic        normal_req_q;   // high asks for normal mode (R2) (R14)
   logic        wake_seen_q;    // sticky: rx seen low outside normal request
   logic [31:0] rdata_q;

   wire take      = HSEL & HREADY & HTRANS[1];
   wire hit_ctrl  = (addr_q == TMC_CTRL_ADDR);
   wire hit_stat  = (addr_q == TMC_STATUS_ADDR);
   wire ctrl_wr   = wr_q & hit_ctrl;
   wire stat_wr   = wr_q & hit_stat;
   wire wake_ev   = ~LINK.rx_out & ~normal_req_q;
   wire [31:0] ctrl_word = {31'h0000_0000, normal_req_q};
   wire [31:0] stat_word = {30'h0000_0000, wake_seen_q, LINK.rx_out};
   // read select decodes the address phase so the word is ready for the data phase
   wire [31:0] rd_mux    = (HADDR == TMC_CTRL_ADDR) ? ctrl_word
                         : ((HADDR == TMC_STATUS_ADDR) ? stat_word : 32'h0000_0000);

   // latch the transfer for its data phase
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wr_q <= 1'b0;
         addr_q <= 32'h0000_0000;
      end else begin
         wr_q <= take & HWRITE;
         addr_q <= take ? HADDR : addr_q;   // idle address phases must not move it
      end
   end

   // ***************************************************************
   // registers; the sticky status bit is set-wins over a write-one clear
   // ***************************************************************
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         normal_req_q <= CTRL_RESET;
         wake_seen_q <= 1'b0;
      end else begin
         if (ctrl_wr) normal_req_q <= HWDATA[CTRL_NORMAL_BIT];            // (R3) (R13)
         wake_seen_q <= wake_ev | (wake_seen_q & ~(stat_wr & HWDATA[STAT_WAKE_BIT]));
      end
   end

   // read data registered for the data phase of the next cycle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) rdata_q <= 32'h0000_0000;
      else if (take && !HWRITE) rdata_q <= rd_mux;
   end

   assign LINK.sleep_request_low = normal_req_q;   // high level = normal requested
   assign HRDATA    = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

endmodule : tmc_host

// >>> tmc_assertions.sv
// concurrent checks on the link and the mode outputs of the mode controller
// assumes one clock domain and the async active-low reset shared by both ends
`timescale 1ns/10ps
module tmc_assertions (
   input wire logic               CLK,
   input wire logic               NRST,
   input wire logic               sleep_request_low,
   input wire logic               rx_out,
   input wire tmc_pkg::tmc_mode_t MODE,
   input wire logic               POWER_OFF_BELOW,
   input wire logic               IO_UNDERVOLTAGE,
   input wire logic               OVERTEMP_TRIP,
   input wire logic               TX_ENABLE,
   input wire logic               BUS_FLOAT
);
   import tmc_pkg::*;
   // ***************************************************************
   // mode decode shared by the properties
   // ***************************************************************
   wire norm = (MODE == TMC_NORMAL);
   wire stby = (MODE == TMC_STANDBY);
   wire calm = !POWER_OFF_BELOW && !OVERTEMP_TRIP; // higher-priority exits excluded

   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);

   chk_mode_onehot: assert property ($onehot(MODE))
      else $error("mode is not one-hot");
   chk_power_off: assert property (POWER_OFF_BELOW |=> MODE == TMC_OFF)
      else $error("low battery did not reach off");
   chk_request_low: assert property (norm && !sleep_request_low && calm |=> stby)
      else $error("request low did not leave normal");
   chk_io_undervolt: assert property (norm && IO_UNDERVOLTAGE && calm |=> stby)
      else $error("io undervoltage did not leave normal");
   chk_hot_trip: assert property (norm && OVERTEMP_TRIP && !POWER_OFF_BELOW
      |=> MODE == TMC_OVERTEMP) else $error("overtemp not entered at once");
   chk_normal_entry: assert property (stby && sleep_request_low && !IO_UNDERVOLTAGE
      && !POWER_OFF_BELOW |=> norm) else $error("normal not entered from standby");
   chk_no_direct_sleep: assert property (norm |=> MODE != TMC_SLEEP)
      else $error("normal went straight to sleep");
   chk_off_quiet: assert property (MODE == TMC_OFF |-> BUS_FLOAT && !TX_ENABLE)
      else $error("bus pins not released in off");
   // the rx line is registered, so one cycle of lag is allowed
   chk_power_on_flag: assert property ($past(MODE) == TMC_OFF && stby |-> ##[0:1] !rx_out)
      else $error("power-on not flagged on rx");
   chk_wake_held: assert property (stby && $past(stby) && !$past(rx_out) |-> !rx_out)
      else $error("pending wake dropped in standby");
   chk_standby_silent: assert property (stby |-> !TX_ENABLE)
      else $error("transmitter enabled in standby");
   chk_hot_float: assert property (MODE == TMC_OVERTEMP |-> BUS_FLOAT && !TX_ENABLE)
      else $error("bus not floating in overtemp");

   cov_sleep: cover property (MODE == TMC_SLEEP ##1 stby);
   cov_hot: cover property (norm ##1 MODE == TMC_OVERTEMP);
   cov_off: cover property (stby ##1 MODE == TMC_OFF);
endmodule : tmc_assertions

// >>> tmc_test.sv
// self-checking bench: host and device ends joined by tmc_if, AHB-Lite master
// assumes the package, interface, both ends and the checker are compiled first
`timescale 1ns/10ps
module tmc_test;
   import tmc_pkg::*;
   localparam int SIL = 20;  // short silence count keeps the run brief
   localparam int UVS = 40;
   typedef struct {string nm; logic [31:0] e; int s;} tmc_note_t;
   // ***************************************************************
   // clock, stimulus and the two ends
   // ***************************************************************
   logic        CLK = 1'h0;
   logic        NRST = 1'h0;
   logic        pon = 1'h0, poff = 1'h0, uv = 1'h0, trip = 1'h0, rel = 1'h0;
   logic        act = 1'h0, bwake = 1'h0, lwake = 1'h0, rxd = 1'h1;
   logic        HSEL = 1'h0, HWRITE = 1'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, aux = 32'h0, rd = 32'h0;
   wire  [31:0] HRDATA;
   wire         HREADYOUT, HRESP, reg_on, sw_o, oe, txe, rxe, bmid, bgnd, bflt;
   tmc_mode_t   MODE;
   tmc_note_t   q[$];
   event        ev;
   int          num_errors = 0, tests_run = 0;

   always #(CLK_PERIOD_NS / 2) CLK = !CLK;
   tmc_if link ();
   tmc_device #(.SILENCE_CYCLES(SIL), .UV_SLP_CYCLES(UVS)) tmc_device_inst (.CLK(CLK),
      .NRST(NRST), .LINK(link), .POWER_ON_ABOVE(pon), .POWER_OFF_BELOW(poff),
      .IO_UNDERVOLTAGE(uv), .OVERTEMP_TRIP(trip), .OVERTEMP_RELEASE(rel), .BUS_ACTIVITY(act),
      .BUS_WAKE_PATTERN(bwake), .LOCAL_WAKE_PIN(lwake), .RX_BUS_DATA(rxd), .MODE(MODE),
      .REGULATOR_ON(reg_on), .REGULATOR_SWITCH_O(sw_o), .REGULATOR_SWITCH_OE(oe),
      .TX_ENABLE(txe), .RX_ENABLE(rxe), .BIAS_MID(bmid), .BIAS_GND(bgnd), .BUS_FLOAT(bflt));
   tmc_host tmc_host_inst (.CLK(CLK), .NRST(NRST), .LINK(link), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
   tmc_assertions tmc_assertions_inst (.CLK(CLK), .NRST(NRST), .MODE(MODE),
      .sleep_request_low(link.sleep_request_low), .rx_out(link.rx_out),
      .POWER_OFF_BELOW(poff), .IO_UNDERVOLTAGE(uv), .OVERTEMP_TRIP(trip), .TX_ENABLE(txe),
      .BUS_FLOAT(bflt));

   // ***************************************************************
   // notes, watcher, bus cycles
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input int s);
      q.push_back('{nm, e, s});
      ->ev;
   endtask : chk
   // the watcher drains every note queued in one time step
   initial begin : watch
      tmc_note_t n;
      logic [31:0] v;
      forever begin
         @(ev);
         while (q.size() > 0) begin
            n = q.pop_front();
            case (n.s)
               0: v = 32'(MODE);
               1: v = {31'h0, link.rx_out};
               2: v = rd;
               3: v = {30'h0, txe, rxe};
               4: v = {29'h0, bmid, bgnd, bflt};
               5: v = {31'h0, oe & sw_o};
               6: v = {31'h0, reg_on};
               default: v = aux;
            endcase
            tests_run++;
            if (v !== n.e) begin
               num_errors++;
               $display("mismatch %s expected %h seen %h", n.nm, n.e, v);
            end
         end
      end
   end
   // ready and read data are taken at the rising edge; every change follows that edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge CLK);
      HSEL <= 1'h1;
      HTRANS <= HTRANS_NONSEQ;
      HADDR <= a;
      HWRITE <= w;
      do @(posedge CLK); while (HREADYOUT !== 1'h1);
      HSEL <= 1'h0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'h1);
      rd = HRDATA;
   endtask : ahb
   task automatic wm(input tmc_mode_t m, input int lim);
      int c = 0;
      while (MODE !== m && c < lim) begin
         @(negedge CLK);
         c++;
      end
      aux = c;
      chk("mode", m, 0);
   endtask : wm
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   initial begin : watchdog
      #(20000 * CLK_PERIOD_NS);
      num_errors++;
      close_out();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin : main
      void'($urandom(44275));
      repeat (6) @(posedge CLK);
      NRST <= 1'h1;
      @(negedge CLK);
      chk("mode", TMC_OFF, 0);
      chk("bias", 3'h1, 4);
      @(posedge CLK) pon <= 1'h1;
      wm(TMC_STANDBY, STARTUP_CYC + 20);
      aux = 32'(aux >= STARTUP_CYC - 2);
      chk("startup", 32'h1, 7);
      @(negedge CLK);
      chk("rx", 32'h0, 1);
      chk("inhibit", 32'h1, 5);
      ahb(1'h0, TMC_STATUS_ADDR, 32'h0);
      chk("status", 32'h2, 2);
      ahb(1'h1, 32'h8, 32'hffff_ffff);
      ahb(1'h0, 32'h8, 32'h0);
      chk("unmapped", 32'h0, 2);
      ahb(1'h1, TMC_CTRL_ADDR, 32'h1);
      wm(TMC_NORMAL, 5);
      chk("txrx", 32'h3, 3);
      // random bus bits must appear one cycle later once pendings are gone
      for (int i = 0; i < 8; i++) begin
         @(posedge CLK) rxd <= 1'($urandom);
         @(posedge CLK);
         @(negedge CLK);
         chk("rx data", {31'h0, rxd}, 1);
      end
      @(posedge CLK) rxd <= 1'h0;
      ahb(1'h1, TMC_CTRL_ADDR, 32'h0);
      wm(TMC_STANDBY, 5);
      @(negedge CLK);
      chk("txrx", 32'h0, 3);
      chk("rx", 32'h1, 1);
      wm(TMC_SLEEP, SLEEP_CYC + 20);
      aux = 32'(aux >= SLEEP_CYC - 5);
      chk("sleep delay", 32'h1, 7);
      @(negedge CLK);
      chk("inhibit", 32'h0, 5);
      chk("regulator", 32'h0, 6);
      @(posedge CLK) lwake <= 1'h1;
      wm(TMC_STANDBY, 5);
      repeat (2) @(negedge CLK);
      chk("rx", 32'h0, 1);
      repeat (SLEEP_CYC + 20) @(negedge CLK);
      chk("mode", TMC_STANDBY, 0);
      chk("rx", 32'h0, 1);
      @(posedge CLK) act <= 1'h1;
      rxd <= 1'h1;
      repeat (2) @(negedge CLK);
      chk("bias", 32'h4, 4);
      @(posedge CLK) act <= 1'h0;
      repeat (SIL + 5) @(negedge CLK);
      chk("bias", 32'h2, 4);
      @(posedge CLK) bwake <= 1'h1;
      @(posedge CLK) bwake <= 1'h0;
      repeat (2) @(negedge CLK);
      chk("regulator", 32'h1, 6);
      repeat (SIL + 10) @(negedge CLK);
      chk("regulator", 32'h0, 6);
      ahb(1'h1, TMC_CTRL_ADDR, 32'h1);
      wm(TMC_NORMAL, 5);
      repeat (2) @(negedge CLK);
      chk("rx", 32'h1, 1);
      @(posedge CLK) uv <= 1'h1;
      wm(TMC_STANDBY, 5);
      @(posedge CLK) lwake <= 1'h0;
      repeat (2) @(negedge CLK);
      chk("rx", 32'h0, 1);
      wm(TMC_SLEEP, UVS + 20);
      repeat (2) @(negedge CLK);
      chk("rx", 32'h1, 1);
      @(posedge CLK) uv <= 1'h0;
      wm(TMC_NORMAL, 10);
      @(posedge CLK) trip <= 1'h1;
      wm(TMC_OVERTEMP, 3);
      @(negedge CLK);
      chk("regulator", 32'h0, 6);
      chk("bias", 32'h1, 4);
      chk("inhibit", 32'h1, 5);
      @(posedge CLK) trip <= 1'h0;
      rel <= 1'h1;
      wm(TMC_STANDBY, 5);
      @(posedge CLK) rel <= 1'h0;
      poff <= 1'h1;
      wm(TMC_OFF, 3);
      repeat (2) @(negedge CLK);
      chk("rx", 32'h1, 1);
      @(negedge CLK);
      close_out();
   end
endmodule : tmc_test
